// File: hw/svm_pkg.sv
// Package of offsets, fields, reset values and timing for the supply voltage monitor control
package svm_pkg;
   // Register word indices (byte address is index times four)
   localparam logic [8:0] IDX_CONFIG = 9'h1e3;
   localparam logic [8:0] IDX_STATUS = 9'h1e4;
   localparam logic [8:0] IDX_TRIM = 9'h1eb;
   localparam logic [8:0] IDX_IRQ_STATUS = 9'h1f0;
   localparam logic [8:0] IDX_IRQ_ENABLE = 9'h1f1;
   localparam logic [8:0] IDX_IRQ_CLEAR = 9'h1f2;
   localparam int ADDR_W = 11;
   // Field positions
   localparam int TRIP_LSB = 0;
   localparam int RANGE_LSB = 4;
   localparam int DUTY_LSB = 6;
   localparam int LVD_BIT = 1;
   localparam int POR_BIT = 0;
   // Writable masks and reset values
   localparam logic [7:0] CONFIG_MASK = 8'h37;
   localparam logic [7:0] TRIM_MASK = 8'hc0;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] TRIM_RESET = 8'h00;
   // Duty cycle codes and period counter width in bits
   localparam logic [1:0] DUTY_128 = 2'h0;
   localparam logic [1:0] DUTY_512 = 2'h1;
   localparam logic [1:0] DUTY_32 = 2'h2;
   localparam logic [1:0] DUTY_8 = 2'h3;
   localparam int PERIOD_W = 10;
   // Reset range code that suppresses the reset
   localparam logic [1:0] RANGE_NO_RESET = 2'h3;
   // Timing: bus read answer latency in cycles
   localparam int READ_WAIT = 1;
endpackage

// File: hw/svm_ctrl.sv
// Supply voltage monitor control: registers, duty cycling, wakeup sampling, interrupts
// Function
// - Trip select code picks comparator trip level
// - Read-only live comparator status register
// - Status bit 1 is live low-voltage trip
// - Status bit 0 is live precision-reset trip
// - Detector switched on and off periodically while asleep
// - Duty field selects 1/128,1/512,1/32,1/8
// - Sleep duty cycling trades latency against power
// - Sample comparators one slow edge after wakeup
`timescale 1ns/1ps
module svm_ctrl
(
   input wire logic CLK, // System clock, 250 MHz
   input wire logic RESET_N, // Asynchronous reset, active low
   input wire logic [10:0] AVS_ADDRESS, // Byte address
   input wire logic AVS_READ, // Read request
   input wire logic AVS_WRITE, // Write request
   input wire logic [31:0] AVS_WRITEDATA, // Write data
   input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes
   output logic [31:0] AVS_READDATA, // Read data
   output logic AVS_WAITREQUEST, // Stall request
   input wire logic SLOW_CLK_TICK, // One-cycle pulse per 32 kHz rising edge
   input wire logic SLEEP, // Device asleep level
   input wire logic POWER_DOWN, // System power-down level
   input wire logic LVD_COMPARATOR, // Analog low-voltage comparator output
   input wire logic POR_COMPARATOR, // Analog precision reset comparator output
   output logic [2:0] TRIP_LEVEL_SELECT, // To analog low-voltage comparator
   output logic [1:0] RESET_RANGE_SELECT, // To analog precision comparator
   output logic DETECTOR_ON, // Detector power enable
   output logic PRECISION_RESET_REQUEST, // Reset request to reset logic
   output logic IRQ // Interrupt, active high level
);
   logic [7:0] voltage_monitor_config;
   logic [7:0] monitor_duty_cycle_trim;
   logic [1:0] irq_status;
   logic [1:0] irq_enable;
   logic low_voltage_tripped;
   logic precision_reset_tripped;
   logic [9:0] period_count;
   logic [9:0] next_period_count;
   logic [9:0] period_last;
   logic pd_prev;
   logic wake_pending;
   logic wake_sample;
   logic [1:0] prev_trip;
   logic [1:0] trip_rise;
   logic [8:0] word_index;
   logic bus_access;
   logic wr_config;
   logic wr_trim;
   logic wr_enable;
   logic wr_clear;

   // Byte address decode to register index; writes need lane 0, reads ignore the lanes
   function automatic logic hit(input logic [8:0] idx, input logic [8:0] want);
      hit = (idx == want);
   endfunction

   assign word_index = AVS_ADDRESS[10:2];
   assign bus_access = AVS_BYTEENABLE[0] && !AVS_WAITREQUEST; // Writes land as wait drops
   assign wr_config = AVS_WRITE && bus_access && hit(word_index, svm_pkg::IDX_CONFIG);
   assign wr_trim = AVS_WRITE && bus_access && hit(word_index, svm_pkg::IDX_TRIM);
   assign wr_enable = AVS_WRITE && bus_access && hit(word_index, svm_pkg::IDX_IRQ_ENABLE);
   assign wr_clear = AVS_WRITE && bus_access && hit(word_index, svm_pkg::IDX_IRQ_CLEAR);

   // Config register; reserved codes are not blocked, software must avoid them
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         voltage_monitor_config <= svm_pkg::CONFIG_RESET;
      else if (wr_config)
         voltage_monitor_config <= AVS_WRITEDATA[7:0] & svm_pkg::CONFIG_MASK;
   end

   // Duty cycle trim register
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         monitor_duty_cycle_trim <= svm_pkg::TRIM_RESET;
      else if (wr_trim)
         monitor_duty_cycle_trim <= AVS_WRITEDATA[7:0] & svm_pkg::TRIM_MASK;
   end

   // Selects driven to the analog comparators
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         TRIP_LEVEL_SELECT <= 3'h0;
         RESET_RANGE_SELECT <= 2'h0;
      end
      else
      begin
         TRIP_LEVEL_SELECT <= voltage_monitor_config[svm_pkg::TRIP_LSB +: 3];
         RESET_RANGE_SELECT <= voltage_monitor_config[svm_pkg::RANGE_LSB +: 2];
      end
   end

   // Period length for the chosen duty code
   always_comb
   begin
      case (monitor_duty_cycle_trim[svm_pkg::DUTY_LSB +: 2])
         svm_pkg::DUTY_128: period_last = 10'h07f;
         svm_pkg::DUTY_512: period_last = 10'h1ff;
         svm_pkg::DUTY_32: period_last = 10'h01f;
         svm_pkg::DUTY_8: period_last = 10'h007;
         default: period_last = 10'h07f;
      endcase
   end

   // Slow-period counter wraps at the selected length
   always_comb
   begin
      next_period_count = period_count;
      if (SLOW_CLK_TICK)
         next_period_count = (period_count >= period_last) ? 10'h000 : period_count + 10'h001;
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         period_count <= 10'h000;
      else
         period_count <= next_period_count;
   end

   // Awake: detector stays on; asleep: on for one slow period per cycle
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         DETECTOR_ON <= 1'b1;
      else
         DETECTOR_ON <= !SLEEP || (next_period_count == 10'h000);
   end

   // Wakeup: first slow edge after power-down release samples settled values
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pd_prev <= 1'b0;
         wake_pending <= 1'b0;
      end
      else
      begin
         pd_prev <= POWER_DOWN;
         if (pd_prev && !POWER_DOWN)
            wake_pending <= 1'b1;
         else if (SLOW_CLK_TICK)
            wake_pending <= 1'b0;
      end
   end
   assign wake_sample = wake_pending && SLOW_CLK_TICK && !POWER_DOWN;

   // Comparator capture: follow live while out of power-down and on, and at wake sample
   // After power-down release the analog levels are still settling, so the
   // status holds until the first slow edge takes the settled values
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         low_voltage_tripped <= 1'b0;
         precision_reset_tripped <= 1'b0;
      end
      else if (wake_sample || (!POWER_DOWN && !pd_prev && !wake_pending && DETECTOR_ON))
      begin
         low_voltage_tripped <= LVD_COMPARATOR;
         precision_reset_tripped <= POR_COMPARATOR;
      end
   end

   // Reset request unless the range code suppresses it
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         PRECISION_RESET_REQUEST <= 1'b0;
      else
         PRECISION_RESET_REQUEST <= precision_reset_tripped &&
            (voltage_monitor_config[svm_pkg::RANGE_LSB +: 2] != svm_pkg::RANGE_NO_RESET);
   end

   // Trip onsets set sticky status; set beats a same-cycle clear
   assign trip_rise = {low_voltage_tripped, precision_reset_tripped} & ~prev_trip;
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         prev_trip <= 2'h0;
         irq_status <= 2'h0;
         irq_enable <= 2'h0;
      end
      else
      begin
         prev_trip <= {low_voltage_tripped, precision_reset_tripped};
         irq_status <= (irq_status & ~(wr_clear ? AVS_WRITEDATA[1:0] : 2'h0)) | trip_rise;
         if (wr_enable)
            irq_enable <= AVS_WRITEDATA[1:0];
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         IRQ <= 1'b0;
      else
         IRQ <= |(irq_status & irq_enable);
   end

   // Bus slave: every access waits one cycle so waitrequest can come from a flop
   // Idle level is high; it drops for the one cycle in which the access completes,
   // costing a cycle on writes but keeping every output registered
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         AVS_WAITREQUEST <= 1'b1;
      else
         AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
   end

   // Read mux; unmapped addresses and reserved bits read zero
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         AVS_READDATA <= 32'h0000_0000;
      else if (AVS_READ && AVS_WAITREQUEST)
      begin
         AVS_READDATA <= 32'h0000_0000;
         if (hit(word_index, svm_pkg::IDX_CONFIG))
            AVS_READDATA[7:0] <= voltage_monitor_config;
         else if (hit(word_index, svm_pkg::IDX_STATUS))
            AVS_READDATA[1:0] <= {low_voltage_tripped, precision_reset_tripped};
         else if (hit(word_index, svm_pkg::IDX_TRIM))
            AVS_READDATA[7:0] <= monitor_duty_cycle_trim;
         else if (hit(word_index, svm_pkg::IDX_IRQ_STATUS))
            AVS_READDATA[1:0] <= irq_status;
         else if (hit(word_index, svm_pkg::IDX_IRQ_ENABLE))
            AVS_READDATA[1:0] <= irq_enable;
      end
   end

   // Checks, grouped by concern; all run on the one clock and reset

   // Register bus
   AST_WAIT_ONE: assert property (@(posedge CLK) disable iff (!RESET_N)
      ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
      else $error("bus access not answered after one wait cycle");
   AST_CONFIG_WRITE: assert property (@(posedge CLK) disable iff (!RESET_N)
      wr_config |=> voltage_monitor_config == ($past(AVS_WRITEDATA[7:0]) & 8'h37))
      else $error("config write not stored");
   AST_STATUS_READ: assert property (@(posedge CLK) disable iff (!RESET_N)
      (AVS_READ && AVS_WAITREQUEST && word_index == svm_pkg::IDX_STATUS) |=>
      AVS_READDATA == {30'h0, $past(low_voltage_tripped), $past(precision_reset_tripped)})
      else $error("status read wrong");
   AST_READ_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
      !AVS_READ |=> $stable(AVS_READDATA))
      else $error("read data changed without a read");

   // Selects and comparator status
   AST_TRIP_SELECT: assert property (@(posedge CLK) disable iff (!RESET_N)
      ##1 TRIP_LEVEL_SELECT == $past(voltage_monitor_config[2:0]))
      else $error("trip select not forwarded");
   AST_RANGE_SELECT: assert property (@(posedge CLK) disable iff (!RESET_N)
      ##1 RESET_RANGE_SELECT == $past(voltage_monitor_config[5:4]))
      else $error("range select not forwarded");
   AST_LVD_LIVE: assert property (@(posedge CLK) disable iff (!RESET_N)
      (!POWER_DOWN && !pd_prev && !wake_pending && DETECTOR_ON) |=>
      low_voltage_tripped == $past(LVD_COMPARATOR))
      else $error("low-voltage bit not live");
   AST_POR_LIVE: assert property (@(posedge CLK) disable iff (!RESET_N)
      (!POWER_DOWN && !pd_prev && !wake_pending && DETECTOR_ON) |=>
      precision_reset_tripped == $past(POR_COMPARATOR))
      else $error("precision bit not live");

   // Duty cycling
   AST_DUTY_WRAP: assert property (@(posedge CLK) disable iff (!RESET_N)
      SLOW_CLK_TICK |=> period_count <= $past(period_last))
      else $error("period counter past its length");
   AST_AWAKE_ON: assert property (@(posedge CLK) disable iff (!RESET_N)
      !SLEEP |=> DETECTOR_ON)
      else $error("detector off while awake");
   AST_SLEEP_OFF: assert property (@(posedge CLK) disable iff (!RESET_N)
      (SLEEP && next_period_count != 10'h000) |=> !DETECTOR_ON)
      else $error("detector on outside its slot while asleep");

   // Wakeup
   AST_WAKE_SAMPLE: assert property (@(posedge CLK) disable iff (!RESET_N)
      wake_sample |=> low_voltage_tripped == $past(LVD_COMPARATOR) && !wake_pending)
      else $error("wake sample missed");
   AST_WAKE_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
      ((pd_prev || wake_pending) && !wake_sample) |=>
      $stable({low_voltage_tripped, precision_reset_tripped}))
      else $error("status moved before the wake sample");

   // Reset request and interrupts
   AST_RESET_SUPPRESS: assert property (@(posedge CLK) disable iff (!RESET_N)
      (RESET_RANGE_SELECT == 2'h3 && $past(RESET_RANGE_SELECT) == 2'h3) |-> ##1
      !PRECISION_RESET_REQUEST || $past(voltage_monitor_config[5:4]) != 2'h3)
      else $error("reset not suppressed");
   AST_RESET_REQUEST: assert property (@(posedge CLK) disable iff (!RESET_N)
      (precision_reset_tripped && voltage_monitor_config[5:4] != 2'h3) |=>
      PRECISION_RESET_REQUEST)
      else $error("reset request missing");
   AST_STICKY_SET: assert property (@(posedge CLK) disable iff (!RESET_N)
      trip_rise[1] |=> irq_status[1])
      else $error("low-voltage onset not latched");
   AST_IRQ_CLEAR: assert property (@(posedge CLK) disable iff (!RESET_N)
      (wr_clear && AVS_WRITEDATA[1] && !trip_rise[1]) |=> !irq_status[1])
      else $error("low-voltage status not cleared");
endmodule

// File: hw/unused_placeholder_note.sv
// Intentionally empty design file
`timescale 1ns/1ps

// File: verification/supply_voltage_monitor_ctrl_tb.sv
// Self-checking bench for the supply voltage monitor control block
`timescale 1ns/1ps
module supply_voltage_monitor_ctrl_tb;
   localparam logic [10:0] A_CFG = 11'h78c;
   localparam logic [10:0] A_STS = 11'h790;
   localparam logic [10:0] A_TRM = 11'h7ac;
   localparam logic [10:0] A_IST = 11'h7c0;
   localparam logic [10:0] A_IEN = 11'h7c4;
   localparam logic [10:0] A_ICL = 11'h7c8;
   logic CLK = 1'h0;
   logic RESET_N = 1'h0;
   logic [10:0] AVS_ADDRESS = 11'h0;
   logic AVS_READ = 1'h0;
   logic AVS_WRITE = 1'h0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [3:0] AVS_BYTEENABLE = 4'h0;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic SLOW_CLK_TICK = 1'h0;
   logic SLEEP = 1'h0;
   logic POWER_DOWN = 1'h0;
   logic LVD_COMPARATOR = 1'h0;
   logic POR_COMPARATOR = 1'h0;
   logic [2:0] TRIP_LEVEL_SELECT;
   logic [1:0] RESET_RANGE_SELECT;
   logic DETECTOR_ON;
   logic PRECISION_RESET_REQUEST;
   logic IRQ;
   logic [31:0] exp_q[$];
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;
   int rises = 0;
   logic last_on = 1'h1;

   svm_ctrl svm_ctrl_inst
   (
      .CLK(CLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .SLOW_CLK_TICK(SLOW_CLK_TICK), .SLEEP(SLEEP), .POWER_DOWN(POWER_DOWN),
      .LVD_COMPARATOR(LVD_COMPARATOR), .POR_COMPARATOR(POR_COMPARATOR),
      .TRIP_LEVEL_SELECT(TRIP_LEVEL_SELECT), .RESET_RANGE_SELECT(RESET_RANGE_SELECT),
      .DETECTOR_ON(DETECTOR_ON), .PRECISION_RESET_REQUEST(PRECISION_RESET_REQUEST), .IRQ(IRQ)
   );

   // Free-running 250 MHz clock
   always #2 CLK = ~CLK;

   task print_verdict;
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input bit ok);
      tests_run++;
      if (!ok)
      begin
         miscompares++;
         $display("[ERR] %0t output check mismatch", $time);
      end
   endtask

   // One bus cycle; a read queues its expected byte, the request is held until wait drops
   task bus(input bit r, input logic [10:0] a, input logic [7:0] d, input bit be);
      int n;
      n = 0;
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_READ <= r;
      AVS_WRITE <= !r;
      AVS_WRITEDATA <= {24'h0, d};
      AVS_BYTEENABLE <= {3'h0, be};
      if (r)
         exp_q.push_back({24'h0, d});
      do
         @(posedge CLK);
      while (AVS_WAITREQUEST !== 1'h0 && n++ < 40);
      if (AVS_WAITREQUEST !== 1'h0)
      begin
         miscompares++;
         $display("[ERR] %0t bus wait timeout", $time);
      end
      AVS_READ <= 1'h0;
      AVS_WRITE <= 1'h0;
   endtask

   task settle;
      repeat (4) @(posedge CLK);
   endtask

   // Comparator, power-down and sleep levels, then time for the capture flops
   task setin(input logic [3:0] v);
      @(posedge CLK);
      {LVD_COMPARATOR, POR_COMPARATOR, POWER_DOWN, SLEEP} <= v;
      settle();
   endtask

   // Tick spaced three cycles apart keeps the long duty periods short in time
   task tick;
      @(posedge CLK);
      SLOW_CLK_TICK <= 1'h1;
      @(posedge CLK);
      SLOW_CLK_TICK <= 1'h0;
      @(posedge CLK);
   endtask

   // Scoreboard: each completed read is matched against the oldest queued value
   always @(posedge CLK)
   begin
      if (AVS_READ === 1'h1 && AVS_WAITREQUEST === 1'h0)
      begin
         tests_run++;
         if (exp_q.size() == 0 || AVS_READDATA !== exp_q.pop_front())
         begin
            miscompares++;
            $display("[ERR] %0t read data mismatch at %h", $time, AVS_ADDRESS);
         end
      end
   end

   // Counts detector power-up edges; phase at entry to sleep is unknown, so a slack of one
   always @(posedge CLK)
   begin
      if (DETECTOR_ON === 1'h1 && last_on === 1'h0)
         rises++;
      last_on <= DETECTOR_ON;
   end

   // Hang guard, well above the roughly 17000 cycles the sequence needs
   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         miscompares++;
         print_verdict();
      end
   end

   // Main sequence
   initial
   begin
      logic [7:0] r;
      logic [7:0] d;
      logic [10:0] regs[4];
      int per[4];
      regs = '{A_CFG, A_STS, A_TRM, A_IST};
      per = '{128, 512, 32, 8};
      void'($urandom(32'h6512));
      repeat (12) @(posedge CLK);
      RESET_N <= 1'h1;
      for (int i = 0; i < 4; i++)
         bus(1'h1, regs[i], 8'h00, 1'h1);
      // Legal trip codes only, every range code, random reserved bits
      for (int i = 0; i < 12; i++)
      begin
         r = 8'($urandom);
         d = {r[7:6], 2'(i % 4), r[3], 3'(4 + i % 3)};
         bus(1'h0, A_CFG, d, 1'h1);
         settle();
         chk(TRIP_LEVEL_SELECT === d[2:0] && RESET_RANGE_SELECT === d[5:4]);
         bus(1'h1, A_CFG, d & 8'h37, 1'h1);
      end
      // Lane-disabled write, read-only write and unmapped read change nothing
      bus(1'h0, A_CFG, 8'h05, 1'h0);
      bus(1'h1, A_CFG, d & 8'h37, 1'h1);
      bus(1'h0, A_STS, 8'hff, 1'h1);
      bus(1'h1, 11'h000, 8'h00, 1'h1);
      for (int i = 0; i < 4; i++)
      begin
         setin({2'(i), 2'h0});
         bus(1'h1, A_STS, {6'h0, 2'(i)}, 1'h1);
      end
      bus(1'h0, A_CFG, 8'h14, 1'h1);
      setin(4'h4);
      chk(PRECISION_RESET_REQUEST === 1'h1);
      bus(1'h0, A_CFG, 8'h34, 1'h1);
      settle();
      chk(PRECISION_RESET_REQUEST === 1'h0);
      bus(1'h1, A_STS, 8'h01, 1'h1);
      // Interrupt raised, masked, unmasked and cleared
      setin(4'h0);
      bus(1'h0, A_ICL, 8'h03, 1'h1);
      bus(1'h0, A_IEN, 8'h03, 1'h1);
      setin(4'h8);
      chk(IRQ === 1'h1);
      bus(1'h1, A_IST, 8'h02, 1'h1);
      bus(1'h0, A_IEN, 8'h00, 1'h1);
      settle();
      chk(IRQ === 1'h0);
      bus(1'h0, A_IEN, 8'h03, 1'h1);
      bus(1'h0, A_ICL, 8'h02, 1'h1);
      settle();
      chk(IRQ === 1'h0);
      bus(1'h1, A_IST, 8'h00, 1'h1);
      // Status frozen in power-down and after release, until the first slow tick
      setin(4'h6);
      bus(1'h1, A_STS, 8'h02, 1'h1);
      setin(4'h4);
      bus(1'h1, A_STS, 8'h02, 1'h1);
      tick();
      settle();
      bus(1'h1, A_STS, 8'h01, 1'h1);
      // Eight duty periods asleep for every duty code
      for (int c = 0; c < 4; c++)
      begin
         r = 8'($urandom);
         bus(1'h0, A_TRM, {2'(c), r[5:0]}, 1'h1);
         bus(1'h1, A_TRM, {2'(c), 6'h00}, 1'h1);
         setin(4'h5);
         rises = 0;
         repeat (8 * per[c]) tick();
         chk(rises >= 7 && rises <= 9);
         setin(4'h4);
      end
      settle();
      chk(exp_q.size() == 0);
      print_verdict();
   end
endmodule
